// ---- src/sstx_status_gen.sv ----
// subframe vucp generator with transmit channel status registers
`timescale 1ns/1ns
`include "sstx_params.svh"

// ****************************************************************
// fifo
// ****************************************************************
module sstx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [WIDTH-1:0] rd_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // sized to the count width so a power-of-two depth does not fold to 0
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign wr_ready_out = (count_r != FULL);
    assign rd_valid_out = (count_r != '0);
    assign rd_data_out = mem_r[rptr_r];
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_r[wptr_r] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wptr_r <= '0;
        end else if (push) begin
            wptr_r <= (wptr_r == LAST) ? '0 : wptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rptr_r <= '0;
        end else if (pop) begin
            rptr_r <= (rptr_r == LAST) ? '0 : rptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in) count_r <= FULL)
        else $error("fifo count beyond depth");
endmodule : sstx_fifo

// ****************************************************************
// top
// ****************************************************************
module sstx_status_gen
    import sstx_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic sub_valid_in,
    output logic sub_ready_out,
    input wire sstx_sub_in_t sub_in,
    output logic sub_valid_out,
    input wire logic sub_ready_in,
    output sstx_sub_out_t sub_out
);
    localparam int OUT_W = $bits(sstx_sub_out_t);

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] validity_r;
    logic [7:0] byte0_r;
    logic [7:0] category_r;
    logic [7:0] src_chan_r;
    logic [7:0] rate_acc_r;
    logic [7:0] word_len_r;
    logic [`SSTX_CS_IDX_W-1:0] frame_idx_r;
    logic [`SSTX_CS_IDX_W-1:0] frame_idx_nxt;

    logic validity_override_en;
    logic validity_sub0_value;
    logic validity_sub1_value;
    logic tx_data_source_sel;
    logic tx_status_source_sel;

    assign validity_override_en = validity_r[`SSTX_BIT_VAL_OVR];
    assign validity_sub0_value = validity_r[`SSTX_BIT_VAL_SUB0];
    assign validity_sub1_value = validity_r[`SSTX_BIT_VAL_SUB1];
    assign tx_data_source_sel = rate_acc_r[`SSTX_BIT_DATA_SRC];
    assign tx_status_source_sel = rate_acc_r[`SSTX_BIT_STAT_SRC];

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = reg_wr_in && (reg_addr_in == ofs);
    endfunction : wr_hit

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            validity_r <= `SSTX_RST_VALIDITY;
        end else if (wr_hit(`SSTX_OFS_VALIDITY)) begin
            validity_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            byte0_r <= `SSTX_RST_BYTE0;
        end else if (wr_hit(`SSTX_OFS_BYTE0)) begin
            byte0_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            category_r <= `SSTX_RST_CATEGORY;
        end else if (wr_hit(`SSTX_OFS_CATEGORY)) begin
            category_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            src_chan_r <= `SSTX_RST_SRC_CHAN;
        end else if (wr_hit(`SSTX_OFS_SRC_CHAN)) begin
            src_chan_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rate_acc_r <= `SSTX_RST_RATE_ACC;
        end else if (wr_hit(`SSTX_OFS_RATE_ACC)) begin
            rate_acc_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            word_len_r <= `SSTX_RST_WORD_LEN;
        end else if (wr_hit(`SSTX_OFS_WORD_LEN)) begin
            word_len_r <= reg_wdata_in;
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `SSTX_OFS_VALIDITY: reg_rdata_out <= validity_r;
                `SSTX_OFS_BYTE0: reg_rdata_out <= byte0_r;
                `SSTX_OFS_CATEGORY: reg_rdata_out <= category_r;
                `SSTX_OFS_SRC_CHAN: reg_rdata_out <= src_chan_r;
                `SSTX_OFS_RATE_ACC: reg_rdata_out <= rate_acc_r;
                `SSTX_OFS_WORD_LEN: reg_rdata_out <= word_len_r;
                `SSTX_OFS_FRAME_IDX: reg_rdata_out <= frame_idx_r;
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // channel status from registers
    // ************************************************************
    // positions 30, 31 and 40 upward stay zero
    function automatic logic reg_status_bit(
        input logic [`SSTX_CS_IDX_W-1:0] idx,
        input logic sub
    );
        logic [`SSTX_CS_USED-1:0] vec;
        logic [3:0] chan;
        vec = '0;
        chan = sub ? {src_chan_r[7:6], 2'b00}
                   : {2'b00, src_chan_r[5:4]};
        vec[7:0] = byte0_r;
        vec[15:8] = category_r;
        vec[19:16] = src_chan_r[3:0];
        vec[23:20] = chan;
        vec[29:24] = rate_acc_r[5:0];
        vec[35:32] = word_len_r[3:0];
        vec[39:36] = word_len_r[7:4];
        if (idx < `SSTX_CS_IDX_W'(`SSTX_CS_USED)) begin
            reg_status_bit = vec[idx[5:0]];
        end else begin
            reg_status_bit = 1'b0;
        end
    endfunction : reg_status_bit

    // ************************************************************
    // subframe composition
    // ************************************************************
    logic push;
    logic fifo_ready;
    logic from_rx;
    logic stat_from_regs;
    logic [`SSTX_CS_IDX_W-1:0] cs_idx;
    sstx_sub_out_t entry;

    assign sub_ready_out = fifo_ready;
    assign push = sub_valid_in && fifo_ready;
    assign from_rx = !tx_data_source_sel;
    // status selection only matters with the receiver as source
    assign stat_from_regs = !from_rx || tx_status_source_sel;
    assign cs_idx = sub_in.block_start ? '0 : frame_idx_r;

    always_comb begin
        entry = '0;
        entry.sub = sub_in.sub;
        entry.block_start = sub_in.block_start;
        entry.data = from_rx ? sub_in.rx_data : sub_in.aif_data;
        if (validity_override_en) begin
            entry.v = sub_in.sub ? validity_sub1_value
                                 : validity_sub0_value;
        end else if (from_rx) begin
            entry.v = sub_in.rx_v;
        end else begin
            entry.v = 1'b0;
        end
        entry.u = (from_rx && !tx_status_source_sel) ? sub_in.rx_u
                                                     : 1'b0;
        entry.c = stat_from_regs ? reg_status_bit(cs_idx, sub_in.sub)
                                 : sub_in.rx_c;
        entry.p = ^{entry.data, entry.v, entry.u, entry.c};
    end

    // one status bit per subframe, both subframes share an index
    always_comb begin
        frame_idx_nxt = frame_idx_r;
        if (push) begin
            if (sub_in.sub) begin
                frame_idx_nxt = (cs_idx == `SSTX_CS_LAST_FRAME) ? '0
                              : cs_idx + 1'b1;
            end else begin
                frame_idx_nxt = cs_idx;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            frame_idx_r <= '0;
        end else begin
            frame_idx_r <= frame_idx_nxt;
        end
    end

    // ************************************************************
    // output buffer
    // ************************************************************
    // the line coder may stall; back-pressure reaches the framer
    logic [OUT_W-1:0] fifo_rd;

    sstx_fifo #(
        .WIDTH(OUT_W),
        .DEPTH(`SSTX_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .wr_valid_in(sub_valid_in),
        .wr_ready_out(fifo_ready),
        .wr_data_in(entry),
        .rd_valid_out(sub_valid_out),
        .rd_ready_in(sub_ready_in),
        .rd_data_out(fifo_rd)
    );

    assign sub_out = sstx_sub_out_t'(fifo_rd);

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_rate_read;
        reg_rd_in && (reg_addr_in == `SSTX_OFS_RATE_ACC);
    endsequence

    sequence s_last_frame_push;
        push && sub_in.sub && (cs_idx == `SSTX_CS_LAST_FRAME);
    endsequence

    a_valid_default: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        push && !validity_override_en && !from_rx |-> entry.v == 1'b0)
        else $error("validity not zero by default");

    a_valid_follow_rx: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        push && !validity_override_en && from_rx
        |-> entry.v == sub_in.rx_v)
        else $error("validity not taken from receiver");

    a_valid_override: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        push && validity_override_en
        |-> entry.v == (sub_in.sub ? validity_r[`SSTX_BIT_VAL_SUB1]
                                   : validity_r[`SSTX_BIT_VAL_SUB0]))
        else $error("override validity wrong");

    a_user_select: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        push |-> entry.u == (!tx_data_source_sel && !tx_status_source_sel
                             && sub_in.rx_u))
        else $error("user bit wrong");

    a_status_block_wrap: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        s_last_frame_push |=> frame_idx_r == '0)
        else $error("status index did not wrap");

    a_status_rx_copy: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        push && !tx_data_source_sel && !tx_status_source_sel
        |-> entry.c == sub_in.rx_c)
        else $error("status not copied from receiver");

    a_status_high_zero: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        push && stat_from_regs
        && cs_idx >= `SSTX_CS_IDX_W'(`SSTX_CS_USED) |-> entry.c == 1'b0)
        else $error("status beyond used bits not zero");

    a_parity_even: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        sub_valid_out |-> ^{sub_out.data, sub_out.v, sub_out.u,
                            sub_out.c, sub_out.p} == 1'b0)
        else $error("subframe parity odd");

    a_reset_values: assert property (@(posedge clk_sys_in)
        $fell(sys_rst_in) |-> rate_acc_r == `SSTX_RST_RATE_ACC
        && word_len_r == `SSTX_RST_WORD_LEN && byte0_r == '0)
        else $error("register reset value wrong");

    a_rate_readback: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        s_rate_read |=> reg_rdata_out == $past(rate_acc_r))
        else $error("readback mismatch");
endmodule : sstx_status_gen

// ---- src/sstx_params.svh ----
// constants for the s/pdif transmit subframe status generator
`ifndef SSTX_PARAMS_SVH
`define SSTX_PARAMS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define SSTX_OFS_VALIDITY 8'h06
`define SSTX_OFS_BYTE0 8'h12
`define SSTX_OFS_CATEGORY 8'h13
`define SSTX_OFS_SRC_CHAN 8'h14
`define SSTX_OFS_RATE_ACC 8'h15
`define SSTX_OFS_WORD_LEN 8'h16
`define SSTX_OFS_FRAME_IDX 8'h40
// ****************************************************************
// reset values
// ****************************************************************
`define SSTX_RST_VALIDITY 8'h00
`define SSTX_RST_BYTE0 8'h00
`define SSTX_RST_CATEGORY 8'h00
`define SSTX_RST_SRC_CHAN 8'h00
`define SSTX_RST_RATE_ACC 8'h71
`define SSTX_RST_WORD_LEN 8'h0B
// ****************************************************************
// field positions
// ****************************************************************
`define SSTX_BIT_VAL_SUB0 5
`define SSTX_BIT_VAL_SUB1 6
`define SSTX_BIT_VAL_OVR 7
`define SSTX_BIT_DATA_SRC 6
`define SSTX_BIT_STAT_SRC 7
// ****************************************************************
// channel status block geometry, fifo depth and audio width
// ****************************************************************
`define SSTX_CS_USED 40
`define SSTX_CS_LAST_FRAME 8'd191
`define SSTX_CS_IDX_W 8
`define SSTX_FIFO_DEPTH 4
`define SSTX_AUDIO_W 24
`endif

// ---- src/sstx_pkg.sv ----
// types shared by the s/pdif transmit subframe status generator
package sstx_pkg;
    `include "sstx_params.svh"

    // one subframe offered by the framer
    typedef struct packed {
        logic sub;
        logic block_start;
        logic [`SSTX_AUDIO_W-1:0] rx_data;
        logic [`SSTX_AUDIO_W-1:0] aif_data;
        logic rx_v;
        logic rx_u;
        logic rx_c;
    } sstx_sub_in_t;

    // one finished subframe payload for the line coder
    typedef struct packed {
        logic sub;
        logic block_start;
        logic [`SSTX_AUDIO_W-1:0] data;
        logic v;
        logic u;
        logic c;
        logic p;
    } sstx_sub_out_t;
endpackage : sstx_pkg

// ---- verification/sstx_coder_model.sv ----
// behavioural line coder taking finished subframes
`timescale 1ns/1ns
module sstx_coder_model
    import sstx_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic sub_valid_in,
    input wire sstx_sub_out_t sub_in,
    input wire logic [1:0] stall_mode_in,
    output logic sub_ready_out,
    output int parity_bad_out
);
    int seed = 53637;
    logic [31:0] rnd;
    initial sub_ready_out = 1'b0;
    initial parity_bad_out = 0;
    // ****************************************************************
    // ready pacing: 0 prompt, 1 random stalls, 2 hold off
    // ****************************************************************
    // moved on the falling edge so the taking edge never races it
    always @(negedge clk_sys_in) begin
        rnd = $random(seed);
        if (sys_rst_in) begin
            sub_ready_out <= 1'b0;
        end else if (stall_mode_in == 2'd0) begin
            sub_ready_out <= 1'b1;
        end else if (stall_mode_in == 2'd1) begin
            sub_ready_out <= rnd[0] | rnd[1];
        end else begin
            sub_ready_out <= 1'b0;
        end
    end
    // a real receiver drops subframes with odd parity
    always @(posedge clk_sys_in) begin
        if (!sys_rst_in && sub_valid_in && sub_ready_out) begin
            if (^{sub_in.data, sub_in.v, sub_in.u, sub_in.c, sub_in.p}) begin
                parity_bad_out <= parity_bad_out + 1;
            end
        end
    end
endmodule : sstx_coder_model

// ---- verification/tb.sv ----
// self-checking bench for the subframe status generator
`timescale 1ns/1ns
module tb;
    import sstx_pkg::*;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic sub_valid_in = 1'b0;
    logic sub_ready_out;
    sstx_sub_in_t sub_in = '0;
    logic sub_valid_out;
    logic sub_ready_in;
    sstx_sub_out_t sub_out;
    logic [1:0] stall_mode = 2'd1;
    int parity_bad;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 53637;
    int idx = 0;
    logic [7:0] sh [0:255];
    logic [7:0] ofs [6] = '{8'h06, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    logic [7:0] ctl15 [6] = '{8'h00, 8'h80, 8'h40, 8'hC0, 8'h00, 8'h40};
    logic [7:0] ov [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA0, 8'hC0};
    sstx_sub_out_t exp_q [$];
    sstx_sub_out_t e;
    logic [31:0] rnd;

    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    sstx_status_gen u_dut (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .sub_valid_in(sub_valid_in),
        .sub_ready_out(sub_ready_out),
        .sub_in(sub_in),
        .sub_valid_out(sub_valid_out),
        .sub_ready_in(sub_ready_in),
        .sub_out(sub_out)
    );

    sstx_coder_model u_coder (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .sub_valid_in(sub_valid_out),
        .sub_in(sub_out),
        .stall_mode_in(stall_mode),
        .sub_ready_out(sub_ready_in),
        .parity_bad_out(parity_bad)
    );

    // ****************************************************************
    // checking helpers
    // ****************************************************************
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    function automatic logic cs_bit(input int i, input logic s);
        logic [39:0] t;
        t = {sh[8'h16], 2'b00, sh[8'h15][5:0],
            s ? {sh[8'h14][7:6], 2'b00} : {2'b00, sh[8'h14][5:4]},
            sh[8'h14][3:0], sh[8'h13], sh[8'h12]};
        return (i < 40) ? t[i] : 1'b0;
    endfunction : cs_bit

    // ****************************************************************
    // register port
    // ****************************************************************
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_in = 1'b0;
        if (a inside {8'h06, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16}) begin
            sh[a] = d;
        end
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a);
        @(negedge clk_sys_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clk_sys_in);
        reg_rd_in = 1'b0;
        check(reg_rdata_out, (a == 8'h40) ? idx[7:0] : sh[a]);
    endtask : reg_read

    // ****************************************************************
    // subframe stream
    // ****************************************************************
    task automatic send_sub(input logic s, input logic bs);
        sstx_sub_in_t d;
        sstx_sub_out_t x;
        logic [31:0] r;
        logic rx_src;
        int k;
        r = $random(seed);
        d.rx_data = r[23:0];
        d.rx_v = r[24];
        d.rx_u = r[25];
        d.rx_c = r[26];
        r = $random(seed);
        d.aif_data = r[23:0];
        d.sub = s;
        d.block_start = bs;
        rx_src = ~sh[8'h15][6];
        if (!s && bs) idx = 0;
        x.sub = s;
        x.block_start = bs;
        x.data = rx_src ? d.rx_data : d.aif_data;
        x.v = sh[8'h06][7] ? (s ? sh[8'h06][6] : sh[8'h06][5])
            : (rx_src & d.rx_v);
        x.u = rx_src & ~sh[8'h15][7] & d.rx_u;
        x.c = (sh[8'h15][6] | sh[8'h15][7]) ? cs_bit(idx, s) : d.rx_c;
        x.p = ^{x.data, x.v, x.u, x.c};
        @(negedge clk_sys_in);
        sub_valid_in = 1'b1;
        sub_in = d;
        for (k = 0; k < 300; k++) begin
            if (sub_ready_out === 1'b1) break;
            @(negedge clk_sys_in);
        end
        if (k == 300) begin
            n_errors++;
            give_verdict();
        end
        @(posedge clk_sys_in);
        exp_q.push_back(x);
        if (s) idx = (idx == 191) ? 0 : idx + 1;
    endtask : send_sub

    task automatic run_frames(input int n, input logic bs);
        for (int f = 0; f < n; f++) begin
            send_sub(1'b0, bs && f == 0);
            send_sub(1'b1, 1'b0);
        end
        @(negedge clk_sys_in);
        sub_valid_in = 1'b0;
    endtask : run_frames

    task automatic drain();
        int k;
        for (k = 0; k < 800; k++) begin
            @(negedge clk_sys_in);
            if (exp_q.size() == 0 && sub_valid_out === 1'b0) break;
        end
        if (k == 800) begin
            n_errors++;
            give_verdict();
        end
    endtask : drain

    always @(posedge clk_sys_in) begin
        if (sub_valid_out === 1'b1 && sub_ready_in === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                check(sub_out.v, e.v);
                check(sub_out.u, e.u);
                check(sub_out.c, e.c);
                check(sub_out.p, e.p);
                check(sub_out.data, e.data);
                check({sub_out.sub, sub_out.block_start},
                    {e.sub, e.block_start});
            end
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        for (int a = 0; a < 256; a++) sh[a] = 8'h00;
        sh[8'h15] = 8'h71;
        sh[8'h16] = 8'h0B;
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        foreach (ofs[k]) reg_read(ofs[k]);
        reg_write(8'h40, 8'h55);
        reg_write(8'h20, 8'h5A);
        reg_read(8'h40);
        reg_read(8'h20);
        // reset contents go out first: bits 24, 28, 29, 32, 33, 35
        run_frames(42, 1'b1);
        drain();
        reg_read(8'h40);
        stall_mode = 2'd2;
        run_frames(2, 1'b0);
        repeat (3) begin
            @(negedge clk_sys_in);
            check(sub_ready_out, 1'b0);
            check(sub_valid_out, 1'b1);
        end
        stall_mode = 2'd1;
        drain();
        check(sub_valid_out, 1'b0);
        for (int m = 0; m < 6; m++) begin
            rnd = $random(seed);
            reg_write(8'h06, ov[m]);
            // emphasis 000/001 only, mode 00, consumer only
            reg_write(8'h12, {4'b0000, rnd[3:1], 1'b0});
            reg_write(8'h13, rnd[15:8]);
            reg_write(8'h14, rnd[23:16]);
            reg_write(8'h15, ctl15[m] | {2'b00, rnd[29:24]});
            rnd = $random(seed);
            reg_write(8'h16, rnd[7:0]);
            foreach (ofs[k]) reg_read(ofs[k]);
            // block start lands mid-block: index must realign
            run_frames((m == 2) ? 194 : 30, 1'b1);
            drain();
            reg_read(8'h40);
        end
        check(parity_bad, 0);
        give_verdict();
    end
endmodule : tb
